// ===== rtl/rpoc_pkg.sv
/*
  Shared constants and types of the RTC pin output controller:
  timing, register offsets, control layout, reset-output states and block state.
  Assumes a 250 MHz system clock and an APB register bus.
*/
package rpoc_pkg;
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned FREQ_FAST_HZ = 32768;
  localparam int unsigned FREQ_MID_HZ = 1024;
  localparam int unsigned FREQ_SLOW_HZ = 1;
  // half periods in pclk cycles, rounded down
  localparam int unsigned HALF_FAST = CLK_HZ / (2 * FREQ_FAST_HZ);
  localparam int unsigned HALF_MID = CLK_HZ / (2 * FREQ_MID_HZ);
  localparam int unsigned HALF_SLOW = CLK_HZ / (2 * FREQ_SLOW_HZ);
  localparam int unsigned RST_REL_MS = 60;
  localparam int unsigned RST_REL_CYC = (CLK_HZ / 1000) * RST_REL_MS;
  localparam int unsigned CNT_W = 27;

  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STAT = 12'h004;
  localparam logic [11:0] OFF_EVT = 12'h008;
  localparam logic [11:0] OFF_MASK = 12'h00C;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  localparam int unsigned EVT_N = 2;
  localparam int unsigned EVT_W = 5;
  localparam int unsigned EV_RX = 2;
  localparam int unsigned EV_DROP = 3;
  localparam int unsigned EV_RESTORE = 4;
  localparam logic [EVT_W-1:0] EVT_RST = 5'h00;

  localparam logic [1:0] FSEL_FAST = 2'h0;
  localparam logic [1:0] FSEL_MID = 2'h1;
  localparam logic [1:0] FSEL_SLOW = 2'h2;

  localparam logic [2:0] FLAG_WAKE = 3'h0;
  localparam logic [2:0] FLAG_ALARM = 3'h1;
  localparam logic [2:0] FLAG_UPDATE = 3'h2;
  localparam logic [2:0] FLAG_EVENT = 3'h3;
  localparam logic [2:0] FLAG_TCOMP = 3'h4;
  localparam logic [2:0] FLAG_INIT = 3'h5;

  // control register, msb first
  typedef struct packed {
    logic [9:0] rsvd;
    logic spi_out_level;
    logic [3:0] filt_len;
    logic [1:0] pull_dn;
    logic [1:0] pull_up;
    logic [3:0] int_sel;
    logic [2:0] flag_sel;
    logic flag_pol;
    logic safe_input_keep;
    logic safe_output_keep;
    logic wake_on_sqw;
    logic [1:0] fsel;
  } rpoc_ctrl_t;

  typedef enum logic [2:0] {
    RST_HOLD = 3'b001,
    RST_DELAY = 3'b010,
    RST_FREE = 3'b100
  } rpoc_rst_t;

  typedef struct packed {
    rpoc_rst_t rst_st;
    logic [CNT_W-1:0] rst_cnt;
    logic low_s1;
    logic low_s2;
    logic [CNT_W-1:0] sqw_cnt;
    logic sqw_lvl;
    logic foe_s1;
    logic foe_s2;
    logic [2:0] scl_sy;
    logic [2:0] sda_sy;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] rx_byte;
    logic ack;
    logic [EVT_N-1:0] ev_s1;
    logic [EVT_N-1:0] ev_s2;
    logic [EVT_N-1:0] ev_flt;
    logic [EVT_N-1:0][3:0] ev_cnt;
    rpoc_ctrl_t ctrl;
    logic [EVT_W-1:0] evt;
    logic [EVT_W-1:0] mask;
    logic sqw_o;
    logic sqw_oe;
    logic int_oe;
    logic flag_o;
    logic flag_oe;
    logic rst_oe;
    logic so_oe;
    logic sda_oe;
    logic irq;
  } rpoc_st_t;
endpackage

// ===== rtl/rpoc_top.sv
/*
  RTC pin output controller: square wave output, interrupt and flag mirror
  outputs, supply-monitor reset output with release delay, safe-mode pin gating,
  filtered event inputs and a thin two-wire serial receiver, behind APB.
  Assumes internal flags arrive on pclk; pins and supply_low are asynchronous.
*/
// Notes on behaviour
// - square wave at 32.768 kHz, 1024 Hz, 1 Hz
// - square wave pin may carry wake timer flag
// - safe mode without output keep floats outputs
// - safe mode without input keep ignores inputs
// - four-wire data out floats in that case
// - enable pin high drives, low floats wave
// - interrupt pulls low on any selected source
// - flag mirror shows chosen flag, chosen polarity
// - reset low on drop, released 60 ms after supply returns
// - events still detected during safe mode
// - event inputs have pulls and noise filter
// - two-wire bits follow host serial clock
// - without reset function, pin drives low
`timescale 1ns/10ps
`default_nettype none
module rpoc_top #(
  parameter int unsigned HALF_FAST = rpoc_pkg::HALF_FAST,
  parameter int unsigned HALF_MID = rpoc_pkg::HALF_MID,
  parameter int unsigned HALF_SLOW = rpoc_pkg::HALF_SLOW,
  parameter int unsigned RST_REL_CYC = rpoc_pkg::RST_REL_CYC,
  parameter bit HAS_RESET_OUT = 1'b1,
  parameter bit HAS_ENABLE_PIN = 1'b1,
  parameter bit FOUR_WIRE = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wake_timer_flag,
  input wire logic alarm_flag,
  input wire logic update_flag,
  input wire logic tempcomp_stall_flag,
  input wire logic init_needed_flag,
  input wire logic supply_low,
  input wire logic square_wave_enable_pin,
  output logic square_wave_output_o,
  output logic square_wave_output_oe,
  output logic int_n_o,
  output logic int_n_oe,
  output logic flag_mirror_output_o,
  output logic flag_mirror_output_oe,
  output logic rst_n_o,
  output logic rst_n_oe,
  input wire logic [rpoc_pkg::EVT_N-1:0] event_trigger_input,
  output logic [rpoc_pkg::EVT_N-1:0] evt_pull_up_en,
  output logic [rpoc_pkg::EVT_N-1:0] evt_pull_dn_en,
  input wire logic ser_clk,
  input wire logic ser_data_i,
  output logic ser_data_o,
  output logic ser_data_oe,
  output logic spi_serial_out_o,
  output logic spi_serial_out_oe,
  output logic irq
);
  rpoc_pkg::rpoc_st_t st_reg;
  rpoc_pkg::rpoc_st_t st_next;

  function automatic logic [rpoc_pkg::CNT_W-1:0] half_of(input logic [1:0] fs);
    logic [rpoc_pkg::CNT_W-1:0] h;
    h = rpoc_pkg::CNT_W'(HALF_FAST - 1);
    if (fs == rpoc_pkg::FSEL_MID)
      h = rpoc_pkg::CNT_W'(HALF_MID - 1);
    else if (fs == rpoc_pkg::FSEL_SLOW)
      h = rpoc_pkg::CNT_W'(HALF_SLOW - 1);
    return h;
  endfunction

  // ************************************************************
  // APB decode
  // ************************************************************
  logic acc;
  logic hit;
  logic wr;
  logic [31:0] stat_word;

  assign acc = psel & penable;
  assign hit = (paddr == rpoc_pkg::OFF_CTRL) | (paddr == rpoc_pkg::OFF_STAT) |
               (paddr == rpoc_pkg::OFF_EVT) | (paddr == rpoc_pkg::OFF_MASK);
  assign wr = acc & pwrite & hit;
  assign pready = psel & penable;
  assign pslverr = acc & ~hit;
  assign stat_word = {st_reg.rx_byte, 18'h00000, st_reg.ev_flt, st_reg.flag_o,
                      st_reg.int_oe, st_reg.sqw_lvl, st_reg.rst_st != rpoc_pkg::RST_FREE};

  always_comb
  begin
    prdata = 32'h0000_0000;
    if (!acc || pwrite)
      prdata = 32'h0000_0000;
    else if (paddr == rpoc_pkg::OFF_CTRL)
      prdata = {10'h000, st_reg.ctrl[21:0]};
    else if (paddr == rpoc_pkg::OFF_STAT)
      prdata = stat_word;
    else if (paddr == rpoc_pkg::OFF_EVT)
      prdata = {27'h0000000, st_reg.evt};
    else if (paddr == rpoc_pkg::OFF_MASK)
      prdata = {27'h0000000, st_reg.mask};
  end

  // ************************************************************
  // next state
  // ************************************************************
  logic safe;
  logic in_ign;
  logic out_off;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic enable_pin;
  logic int_any;
  logic sel_flag;
  logic event_flag;
  logic [rpoc_pkg::EVT_W-1:0] ev_set;
  logic [rpoc_pkg::EVT_W-1:0] ev_clr;

  always_comb
  begin
    st_next = st_reg;
    ev_set = '0;
    ev_clr = '0;
    safe = st_reg.rst_st != rpoc_pkg::RST_FREE;
    in_ign = safe & ~st_reg.ctrl.safe_input_keep;
    out_off = safe & ~st_reg.ctrl.safe_output_keep;

    // synchronisers; first stages feed only the second
    st_next.low_s1 = supply_low;
    st_next.low_s2 = st_reg.low_s1;
    st_next.foe_s1 = square_wave_enable_pin;
    st_next.foe_s2 = st_reg.foe_s1;
    st_next.scl_sy = {st_reg.scl_sy[1:0], ser_clk};
    st_next.sda_sy = {st_reg.sda_sy[1:0], ser_data_i};
    st_next.ev_s1 = event_trigger_input;
    st_next.ev_s2 = st_reg.ev_s1;

    // supply monitor and reset output hold
    case (st_reg.rst_st)
      rpoc_pkg::RST_HOLD:
      begin
        st_next.rst_cnt = '0;
        if (!st_reg.low_s2)
          st_next.rst_st = rpoc_pkg::RST_DELAY;
      end
      rpoc_pkg::RST_DELAY:
      begin
        st_next.rst_cnt = st_reg.rst_cnt + 1'b1;
        if (st_reg.low_s2)
          st_next.rst_st = rpoc_pkg::RST_HOLD;
        else if (st_reg.rst_cnt == rpoc_pkg::CNT_W'(RST_REL_CYC - 1))
        begin
          st_next.rst_st = rpoc_pkg::RST_FREE;
          ev_set[rpoc_pkg::EV_RESTORE] = 1'b1;
        end
      end
      rpoc_pkg::RST_FREE:
      begin
        if (st_reg.low_s2)
        begin
          st_next.rst_st = rpoc_pkg::RST_HOLD;
          ev_set[rpoc_pkg::EV_DROP] = 1'b1;
        end
      end
      default:
        st_next.rst_st = rpoc_pkg::RST_HOLD;
    endcase

    // square wave generator
    if (st_reg.sqw_cnt >= half_of(st_reg.ctrl.fsel))
    begin
      st_next.sqw_cnt = '0;
      st_next.sqw_lvl = ~st_reg.sqw_lvl;
    end
    else
      st_next.sqw_cnt = st_reg.sqw_cnt + 1'b1;
    if (st_reg.ctrl.fsel == 2'h3)
      st_next.sqw_lvl = 1'b0;

    // event inputs: filter then rising edge, never gated by safe mode
    for (int i = 0; i < rpoc_pkg::EVT_N; i++)
    begin
      if (st_reg.ev_s2[i] == st_reg.ev_flt[i])
        st_next.ev_cnt[i] = 4'h0;
      else if (st_reg.ev_cnt[i] >= st_reg.ctrl.filt_len)
      begin
        st_next.ev_cnt[i] = 4'h0;
        st_next.ev_flt[i] = st_reg.ev_s2[i];
        ev_set[i] = st_reg.ev_s2[i];
      end
      else
        st_next.ev_cnt[i] = st_reg.ev_cnt[i] + 4'h1;
    end

    // two-wire receiver clocked by the host's serial clock edges
    scl_rise = st_reg.scl_sy[1] & ~st_reg.scl_sy[2];
    scl_fall = ~st_reg.scl_sy[1] & st_reg.scl_sy[2];
    start_c = st_reg.scl_sy[1] & ~st_reg.sda_sy[1] & st_reg.sda_sy[2];
    stop_c = st_reg.scl_sy[1] & st_reg.sda_sy[1] & ~st_reg.sda_sy[2];
    if (in_ign || start_c || stop_c)
    begin
      st_next.bit_cnt = 4'h0;
      st_next.ack = 1'b0;
    end
    else if (scl_rise && st_reg.bit_cnt < 4'h8)
    begin
      st_next.shreg = {st_reg.shreg[6:0], st_reg.sda_sy[1]};
      st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
    end
    else if (scl_fall && st_reg.bit_cnt == 4'h8)
    begin
      if (!st_reg.ack)
      begin
        st_next.ack = 1'b1;
        st_next.rx_byte = st_reg.shreg;
        ev_set[rpoc_pkg::EV_RX] = 1'b1;
      end
      else
      begin
        st_next.ack = 1'b0;
        st_next.bit_cnt = 4'h0;
      end
    end
    st_next.sda_oe = st_next.ack & ~in_ign;

    // registers; a set in the clearing cycle wins
    if (wr && paddr == rpoc_pkg::OFF_CTRL)
      st_next.ctrl = rpoc_pkg::rpoc_ctrl_t'({10'h000, pwdata[21:0]});
    if (wr && paddr == rpoc_pkg::OFF_EVT)
      ev_clr = pwdata[rpoc_pkg::EVT_W-1:0];
    if (wr && paddr == rpoc_pkg::OFF_MASK)
      st_next.mask = pwdata[rpoc_pkg::EVT_W-1:0];
    st_next.evt = (st_reg.evt & ~ev_clr) | ev_set;
    st_next.irq = |(st_reg.evt & st_reg.mask);

    // pin drivers
    event_flag = |st_reg.evt[rpoc_pkg::EVT_N-1:0];
    enable_pin = HAS_ENABLE_PIN ? (st_reg.foe_s2 & ~in_ign) : 1'b1;
    st_next.sqw_o = st_reg.ctrl.wake_on_sqw ? wake_timer_flag : st_reg.sqw_lvl;
    st_next.sqw_oe = enable_pin & ~out_off;
    int_any = (st_reg.ctrl.int_sel[0] & wake_timer_flag) |
              (st_reg.ctrl.int_sel[1] & update_flag) |
              (st_reg.ctrl.int_sel[2] & alarm_flag) |
              (st_reg.ctrl.int_sel[3] & event_flag);
    st_next.int_oe = int_any & ~out_off;
    case (st_reg.ctrl.flag_sel)
      rpoc_pkg::FLAG_WAKE: sel_flag = wake_timer_flag;
      rpoc_pkg::FLAG_ALARM: sel_flag = alarm_flag;
      rpoc_pkg::FLAG_UPDATE: sel_flag = update_flag;
      rpoc_pkg::FLAG_EVENT: sel_flag = event_flag;
      rpoc_pkg::FLAG_TCOMP: sel_flag = tempcomp_stall_flag;
      rpoc_pkg::FLAG_INIT: sel_flag = init_needed_flag;
      default: sel_flag = 1'b0;
    endcase
    st_next.flag_o = sel_flag ^ st_reg.ctrl.flag_pol;
    st_next.flag_oe = ~out_off;
    st_next.rst_oe = HAS_RESET_OUT ? safe : 1'b1;
    st_next.so_oe = FOUR_WIRE & ~in_ign;
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg <= '0;
      st_reg.rst_st <= rpoc_pkg::RST_HOLD;
      st_reg.ctrl <= rpoc_pkg::CTRL_RST;
      st_reg.evt <= rpoc_pkg::EVT_RST;
      st_reg.rst_oe <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  assign square_wave_output_o = st_reg.sqw_o;
  assign square_wave_output_oe = st_reg.sqw_oe;
  assign int_n_o = 1'b0;
  assign int_n_oe = st_reg.int_oe;
  assign flag_mirror_output_o = st_reg.flag_o;
  assign flag_mirror_output_oe = st_reg.flag_oe;
  assign rst_n_o = 1'b0;
  assign rst_n_oe = st_reg.rst_oe;
  assign evt_pull_up_en = st_reg.ctrl.pull_up;
  assign evt_pull_dn_en = st_reg.ctrl.pull_dn & ~st_reg.ctrl.pull_up;
  assign ser_data_o = 1'b0;
  assign ser_data_oe = st_reg.sda_oe;
  assign spi_serial_out_o = st_reg.ctrl.spi_out_level;
  assign spi_serial_out_oe = st_reg.so_oe;
  assign irq = st_reg.irq;
endmodule
`default_nettype wire

// ===== test/rpoc_monitor.sv
/* Port checker of the pin output controller.
   Bound to rpoc_top; its counts follow the design's parameters. */
`timescale 1ns/10ps
`default_nettype none
module rpoc_monitor #(
  parameter int unsigned HALF_FAST = 4,
  parameter int unsigned HALF_MID = 8,
  parameter int unsigned HALF_SLOW = 16,
  parameter int unsigned RST_REL_CYC = 50
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic supply_low,
  input wire logic square_wave_enable_pin,
  input wire logic square_wave_output_o,
  input wire logic square_wave_output_oe,
  input wire logic int_n_o,
  input wire logic int_n_oe,
  input wire logic flag_mirror_output_oe,
  input wire logic rst_n_o,
  input wire logic rst_n_oe,
  input wire logic [rpoc_pkg::EVT_N-1:0] evt_pull_up_en,
  input wire logic [rpoc_pkg::EVT_N-1:0] evt_pull_dn_en
);
  // ****
  // helper counters
  // ****
  logic [31:0] wr_age;
  logic [31:0] gap_cnt;
  logic [31:0] low_cnt;
  logic keep_out;
  logic ctrl_wr;
  assign ctrl_wr = psel && penable && pwrite && paddr == 12'h000;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_age <= 32'h0;
      gap_cnt <= 32'h0;
      low_cnt <= 32'h0;
      keep_out <= 1'h0;
    end
    else
    begin
      wr_age <= (ctrl_wr || supply_low || $changed(square_wave_enable_pin)) ? 32'h0 : wr_age + 32'h1;
      gap_cnt <= $changed(square_wave_output_o) ? 32'h1 : gap_cnt + 32'h1;
      low_cnt <= supply_low ? 32'h0 : low_cnt + 32'h1;
      if (ctrl_wr)
        keep_out <= pwdata[3];
    end
  end
  // ****
  // assertions
  // ****
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_drop;
    supply_low [*6];
  endsequence
  a_ready_zero: assert property (s_access |-> pready)
    else $error("pready missing in access phase");
  a_err_map: assert property (s_access |->
    pslverr == !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00C}))
    else $error("pslverr wrong for address");
  a_rdata_idle: assert property (!(psel && penable) |-> prdata == 32'h0)
    else $error("prdata not zero outside access");
  a_drop_hold: assert property (s_drop |-> rst_n_oe)
    else $error("reset output not pulled on supply drop");
  a_release_wait: assert property ($fell(rst_n_oe) |->
    low_cnt >= RST_REL_CYC && low_cnt <= RST_REL_CYC + 8)
    else $error("reset output released at wrong time");
  a_safe_floats: assert property (rst_n_oe && $past(rst_n_oe, 2) && !keep_out
    && !$past(keep_out) |-> !square_wave_output_oe && !int_n_oe && !flag_mirror_output_oe)
    else $error("output driven in safe mode");
  a_enable_low: assert property (!square_wave_enable_pin [*4] |-> !square_wave_output_oe)
    else $error("square wave driven with enable low");
  a_wave_half: assert property ($changed(square_wave_output_o) && wr_age > gap_cnt + 4
    |-> gap_cnt inside {HALF_FAST, HALF_MID, HALF_SLOW})
    else $error("square wave half period wrong");
  a_pull_excl: assert property ((evt_pull_up_en & evt_pull_dn_en) == '0)
    else $error("pull-up and pull-down both on");
  a_drain_low: assert property (int_n_o == 1'h0 && rst_n_o == 1'h0)
    else $error("open-drain pin driven high");
endmodule
`default_nettype wire

// ===== test/rpoc_host_model.sv
/* Two-wire bus host model: frames bytes on serial clock and data.
   Assumes the bench resolves the data line with a pull-up. */
`timescale 1ns/10ps
`default_nettype none
module rpoc_host_model (
  input wire logic pclk,
  input wire logic ser_data_oe,
  output logic ser_clk,
  output logic sda_low
);
  // ****
  // bus framing
  // ****
  logic ack_seen;
  logic dnext;
  initial
  begin
    ser_clk = 1'h1;
    sda_low = 1'h0;
    dnext = 1'h0;
    ack_seen = 1'h0;
  end
  // third of the link period, clock idles high between frames
  task automatic step(input logic c);
    repeat (10) @(posedge pclk);
    ser_clk <= c;
    sda_low <= dnext;
  endtask
  // data changes only while the clock is low
  task automatic bit_out(input logic d);
    step(1'h0);
    dnext = d;
    step(1'h0);
    step(1'h1);
  endtask
  task automatic send_byte(input logic [7:0] b);
    dnext = 1'h1;
    step(1'h1);
    for (int i = 7; i >= 0; i--)
      bit_out(!b[i]);
    bit_out(1'h0);
    ack_seen = ser_data_oe;
    step(1'h0);
    dnext = 1'h1;
    step(1'h0);
    step(1'h1);
    dnext = 1'h0;
    step(1'h1);
  endtask
endmodule
`default_nettype wire

// ===== test/rpoc_top_bench.sv
/* Self-checking bench of the pin output controller.
   Drives APB, pins and the host model; counts shortened by parameters. */
`timescale 1ns/10ps
`default_nettype none
module rpoc_top_bench;
  // ****
  // stimulus and checking
  // ****
  localparam int unsigned RC = 50;
  typedef struct packed {
    logic [31:0] ctrl;
    logic [4:0] flg;
    logic fexp;
    logic iexp;
  } rpoc_row_t;
  rpoc_row_t rows [8] = '{'{32'h0, 5'h01, 1'h1, 1'h0}, '{32'h40, 5'h01, 1'h0, 1'h0},
    '{32'h60, 5'h02, 1'h0, 1'h0}, '{32'h280, 5'h04, 1'h1, 1'h0}, '{32'h4C0, 5'h1F, 1'h0, 1'h1},
    '{32'h900, 5'h0A, 1'h1, 1'h1}, '{32'h1140, 5'h10, 1'h1, 1'h0}, '{32'h200, 5'h01, 1'h1, 1'h1}};
  int unsigned halves [3] = '{4, 8, 16};
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic supply_low = 1'h0;
  logic square_wave_enable_pin = 1'h1;
  logic [4:0] flags = 5'h0;
  logic [1:0] event_trigger_input = 2'h0;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, rerr, ser_clk, sda_low, ser_data_i, ser_data_oe, irq;
  logic square_wave_output_o, square_wave_output_oe, int_n_oe, rst_n_oe;
  logic flag_mirror_output_o, flag_mirror_output_oe, spi_oe;
  logic [1:0] evt_pull_up_en, evt_pull_dn_en;
  int fail_count = 0;
  int check_count = 0;
  int n;
  assign ser_data_i = !(sda_low || ser_data_oe);
  always #2 pclk = ~pclk;
  rpoc_top #(.HALF_FAST(4), .HALF_MID(8), .HALF_SLOW(16), .RST_REL_CYC(RC)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wake_timer_flag(flags[0]), .alarm_flag(flags[1]), .update_flag(flags[2]),
    .tempcomp_stall_flag(flags[3]), .init_needed_flag(flags[4]), .supply_low(supply_low),
    .square_wave_enable_pin(square_wave_enable_pin), .square_wave_output_o(square_wave_output_o),
    .square_wave_output_oe(square_wave_output_oe), .int_n_o(), .int_n_oe(int_n_oe),
    .flag_mirror_output_o(flag_mirror_output_o), .flag_mirror_output_oe(flag_mirror_output_oe),
    .rst_n_o(), .rst_n_oe(rst_n_oe), .event_trigger_input(event_trigger_input),
    .evt_pull_up_en(evt_pull_up_en), .evt_pull_dn_en(evt_pull_dn_en), .ser_clk(ser_clk),
    .ser_data_i(ser_data_i), .ser_data_o(), .ser_data_oe(ser_data_oe), .spi_serial_out_o(),
    .spi_serial_out_oe(spi_oe), .irq(irq));
  rpoc_host_model u_host (.pclk(pclk), .ser_data_oe(ser_data_oe), .ser_clk(ser_clk),
    .sda_low(sda_low));
  task automatic tick(input int c);
    repeat (c) @(posedge pclk);
  endtask
  task automatic check(input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x)
    begin
      fail_count++;
      $display("Error at %0t: got %h want %h", $time, s, x);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    tick(1);
    penable <= 1'h1;
    do
    begin
      tick(1);
    end
    while (pready !== 1'h1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    tick(1);
  endtask
  task automatic gap(output int c);
    logic v;
    v = square_wave_output_o;
    c = 0;
    while (square_wave_output_o === v && c < 99)
    begin
      tick(1);
      c++;
    end
  endtask
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    tick(16);
    presetn <= 1'h1;
    tick(1);
    check(rst_n_oe, 1'h1);
    check(square_wave_output_oe, 1'h0);
    tick(RC + 10);
    check(rst_n_oe, 1'h0);
    apb(1'h0, 12'h008, 32'h0);
    check(rdat[4], 1'h1);
    apb(1'h1, 12'h008, 32'h1F);
    apb(1'h1, 12'h000, 32'hFFFF_FFFF);
    apb(1'h0, 12'h000, 32'h0);
    check(rdat, 32'h003F_FFFF);
    check(evt_pull_dn_en, 2'h0);
    check(evt_pull_up_en, 2'h3);
    apb(1'h1, 12'h010, 32'h1234);
    check(rerr, 1'h1);
    apb(1'h0, 12'h00C, 32'h0);
    check(rdat, 32'h0);
    foreach (rows[i])
    begin
      apb(1'h1, 12'h000, rows[i].ctrl);
      flags <= rows[i].flg;
      tick(4);
      check(flag_mirror_output_o, rows[i].fexp);
      check(flag_mirror_output_oe, 1'h1);
      check(int_n_oe, rows[i].iexp);
    end
    foreach (halves[f])
    begin
      apb(1'h1, 12'h000, 32'(f));
      tick(40);
      gap(n);
      gap(n);
      check(n, halves[f]);
      check(square_wave_output_oe, 1'h1);
    end
    square_wave_enable_pin <= 1'h0;
    tick(5);
    check(square_wave_output_oe, 1'h0);
    square_wave_enable_pin <= 1'h1;
    apb(1'h1, 12'h000, 32'h4);
    tick(2);
    check(square_wave_output_o, 1'h1);
    tick(4);
    check(square_wave_output_o, 1'h1);
    flags <= 5'h0;
    tick(3);
    check(square_wave_output_o, 1'h0);
    // filter of four cycles swallows a two-cycle glitch
    apb(1'h1, 12'h000, 32'h0006_0000);
    apb(1'h1, 12'h00C, 32'h1);
    event_trigger_input <= 2'h1;
    tick(2);
    event_trigger_input <= 2'h0;
    tick(10);
    check(irq, 1'h0);
    event_trigger_input <= 2'h1;
    tick(12);
    check(irq, 1'h1);
    apb(1'h1, 12'h00C, 32'h0);
    tick(2);
    check(irq, 1'h0);
    apb(1'h1, 12'h00C, 32'h1);
    tick(2);
    check(irq, 1'h1);
    apb(1'h1, 12'h008, 32'h1);
    tick(2);
    check(irq, 1'h0);
    supply_low <= 1'h1;
    tick(8);
    check(rst_n_oe, 1'h1);
    check(square_wave_output_oe, 1'h0);
    check(flag_mirror_output_oe, 1'h0);
    check(spi_oe, 1'h0);
    event_trigger_input <= 2'h3;
    tick(12);
    apb(1'h0, 12'h008, 32'h0);
    check(rdat[4:0], 5'h0A);
    u_host.send_byte(8'h3C);
    check(u_host.ack_seen, 1'h0);
    supply_low <= 1'h0;
    tick(RC + 10);
    check(rst_n_oe, 1'h0);
    u_host.send_byte(8'hA5);
    check(u_host.ack_seen, 1'h1);
    apb(1'h0, 12'h004, 32'h0);
    check(rdat[31:24], 8'hA5);
    complete_run();
  end
  initial
  begin
    tick(20000);
    fail_count++;
    complete_run();
  end
endmodule
bind rpoc_top rpoc_monitor #(.HALF_FAST(HALF_FAST), .HALF_MID(HALF_MID),
  .HALF_SLOW(HALF_SLOW), .RST_REL_CYC(RST_REL_CYC)) u_mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .supply_low(supply_low),
  .square_wave_enable_pin(square_wave_enable_pin), .square_wave_output_o(square_wave_output_o),
  .square_wave_output_oe(square_wave_output_oe), .int_n_o(int_n_o), .int_n_oe(int_n_oe),
  .flag_mirror_output_oe(flag_mirror_output_oe), .rst_n_o(rst_n_o), .rst_n_oe(rst_n_oe),
  .evt_pull_up_en(evt_pull_up_en), .evt_pull_dn_en(evt_pull_dn_en));
`default_nettype wire
